//--- rtl/vis_pkg.sv
// package for the vectored interrupt sequencer: constants and carrier types
// Function
// R1: external channels ranked six highest down to one lowest.
// R2: equipment holds its request line until the computer recognises it.
// R3: external channel n forces storage address to entrance 0001n.
// R4: external mode blocks requests until exit 00017 instruction executes.
// R5: return jump stores next main address in target lower half.
// R6: entrance jumping straight to exit continues at nullification 00020 or 00031.
// R7: six internal sources for registers 1,2,4,5,6,7; none for register 3.
// R8: armed monitor raises internal request when that buffer transfer ends.
// R9: internal requests ranked seven highest; only act with no external request.
// R10: internal register j forces storage address to entrance 0002j.
// R11: internal mode ends only after an instruction is read from 00030.
// R12: no request acted on while function is 70, repeat nonzero, or g set.
// R13: monitor flag clears only once its internal request is acknowledged.
// R14: requests are sampled and arbitrated only at instruction boundaries.
package vis_pkg;
	// ------------------------------------------------------------------
	// widths and special addresses (octal)
	// ------------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int FUNC_W = 6;
	localparam logic [ADDR_W-1:0] EXT_ENTRY_BASE = 15'h0008; // octal 00010
	localparam logic [ADDR_W-1:0] EXT_EXIT_ADDR  = 15'h000F; // octal 00017
	localparam logic [ADDR_W-1:0] EXT_NULL_ADDR  = 15'h0010; // octal 00020
	localparam logic [ADDR_W-1:0] INT_ENTRY_BASE = 15'h0010; // octal 00020
	localparam logic [ADDR_W-1:0] INT_EXIT_ADDR  = 15'h0018; // octal 00030
	localparam logic [ADDR_W-1:0] INT_NULL_ADDR  = 15'h0019; // octal 00031
	localparam logic [FUNC_W-1:0] FUNC_REPEAT    = 6'h38;    // octal 70
	localparam logic [FUNC_W-1:0] FUNC_ARM_MON   = 6'h3C;    // octal 74
	localparam logic [7:0]        MON_VALID      = 8'hF6;    // registers 1,2,4..7
	localparam logic [7:0]        MON_RESET      = 8'h00;
	localparam logic [2:0]        SRC_NONE       = 3'h0;

	// interrupt status: idle, external or internal mode active
	typedef enum logic [1:0] {VIS_IDLE, VIS_EXT, VIS_INT} vis_mode_t;

	// instruction boundary report from the control section
	typedef struct packed {
		logic              boundary;  // last cycle of an instruction
		logic [FUNC_W-1:0] func;      // function code of finished instruction
		logic [ADDR_W-1:0] addr;      // address it was read from
		logic              retJump;   // it was a return jump
		logic [ADDR_W-1:0] target;    // return jump target
		logic [2:0]        jField;    // j designator
		logic              repeatBusy;// repeat counter nonzero
		logic              gFlag;     // g designator
	} vis_instr_t;

	// forced entrance toward the storage address register
	typedef struct packed {
		logic              load;      // one-cycle pulse: load storage address
		logic [ADDR_W-1:0] addr;
	} vis_entry_t;
endpackage

//--- rtl/vis_sequencer.sv
// vectored interrupt sequencer: priority, entrance forcing, mode tracking
`timescale 1ns/100ps
module vis_sequencer
	import vis_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// request sources
	input  wire logic [6:1] extRequest,
	input  wire logic [7:1] bufferActive,
	// instruction boundary report
	input  wire vis_instr_t instr,
	// sequencing outputs
	output vis_entry_t      entry,
	output logic [2:0]      source,
	output vis_mode_t       mode,
	output logic [7:1]      monitorArmed,
	output logic            storeLower,
	output logic [ADDR_W-1:0] storeAddr,
	output logic [ADDR_W-1:0] storeData
);
	// ------------------------------------------------------------------
	// request gathering
	// ------------------------------------------------------------------
	logic [7:1] intRequest;
	logic       extAny;
	logic       intAny;
	logic [2:0] extPick;
	logic [2:0] intPick;
	logic       inhibit;
	logic       grant;

	// an armed monitor with no active buffer is a request
	assign intRequest = monitorArmed & ~bufferActive & MON_VALID[7:1]; // R8 R7
	assign extAny     = |extRequest;
	assign intAny     = |intRequest;
	assign inhibit    = (instr.func == FUNC_REPEAT) || instr.repeatBusy || instr.gFlag; // R12

	// highest number wins, lower ones wait for the line to be held
	always_comb begin
		extPick = SRC_NONE;
		intPick = SRC_NONE;
		for (int i = 1; i <= 6; i++) begin
			if (extRequest[i]) begin
				extPick = 3'(i); // R1
			end
		end
		for (int i = 1; i <= 7; i++) begin
			if (intRequest[i]) begin
				intPick = 3'(i); // R9
			end
		end
	end

	// grant only at a boundary and only when no mode is open
	assign grant = instr.boundary && (mode == VIS_IDLE) && !inhibit && (extAny || intAny); // R14

	// ------------------------------------------------------------------
	// mode tracking
	// ------------------------------------------------------------------
	logic exitExt;
	logic exitInt;
	assign exitExt = instr.boundary && (instr.addr == EXT_EXIT_ADDR); // R4
	assign exitInt = instr.boundary && (instr.addr == INT_EXIT_ADDR); // R11

	// mode opens on grant, closes only at its own exit location
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode   <= VIS_IDLE;
			source <= SRC_NONE;
		end else begin
			case (mode)
				VIS_IDLE: begin
					if (grant) begin
						mode   <= extAny ? VIS_EXT : VIS_INT; // R9
						source <= extAny ? extPick : intPick;
					end
				end
				VIS_EXT: begin
					if (exitExt) begin
						mode   <= VIS_IDLE; // R4
						source <= SRC_NONE;
					end
				end
				VIS_INT: begin
					if (exitInt) begin
						mode   <= VIS_IDLE; // R11
						source <= SRC_NONE;
					end
				end
				default: begin
					mode   <= VIS_IDLE;
					source <= SRC_NONE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// entrance forcing and return-jump handling
	// ------------------------------------------------------------------
	// where the interrupted program resumes; any other jump or skip that finishes at the
	// granting boundary is not visible here, so only straight-line flow and return jumps are covered
	logic [ADDR_W-1:0] resumeAddr;
	logic [ADDR_W-1:0] entranceAddr;
	logic              atEntrance;

	assign entranceAddr = ((mode == VIS_INT) ? INT_ENTRY_BASE : EXT_ENTRY_BASE)
	                      + ADDR_W'(source);
	assign atEntrance   = (mode != VIS_IDLE) && (instr.addr == entranceAddr); // R5

	// captured at the grant: a return jump there has already moved the program on
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			resumeAddr <= '0;
		end else if (grant) begin
			resumeAddr <= instr.retJump ? (instr.target + 15'h0001)
			                            : (instr.addr + 15'h0001); // R5
		end
	end

	// a return jump into an exit with no grant at that boundary makes the next step the nullification slot
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			entry      <= '0;
			storeLower <= 1'b0;
			storeAddr  <= '0;
			storeData  <= '0;
		end else begin
			entry.load <= 1'b0;
			storeLower <= 1'b0;
			// the finishing instruction always completes its own store, grant or not
			if (instr.boundary && instr.retJump) begin
				storeLower <= 1'b1; // R5
				storeAddr  <= instr.target;
				storeData  <= atEntrance ? resumeAddr : (instr.addr + 15'h0001); // R5
			end
			if (grant) begin
				entry.load <= 1'b1;
				entry.addr <= extAny ? (EXT_ENTRY_BASE + ADDR_W'(extPick))  // R3
				                     : (INT_ENTRY_BASE + ADDR_W'(intPick)); // R10
			end else if (instr.boundary && instr.retJump) begin
				entry.load <= 1'b1;
				if (instr.target == EXT_EXIT_ADDR) begin
					entry.addr <= EXT_NULL_ADDR; // R6
				end else if (instr.target == INT_EXIT_ADDR) begin
					entry.addr <= INT_NULL_ADDR; // R6
				end else begin
					entry.addr <= instr.target + 15'h0001; // R5
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// buffer monitor flags
	// ------------------------------------------------------------------
	// arming wins over an acknowledge of the same register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			monitorArmed <= MON_RESET[7:1];
		end else begin
			for (int i = 1; i <= 7; i++) begin
				if (instr.boundary && instr.func == FUNC_ARM_MON
				    && instr.jField == 3'(i) && MON_VALID[i]) begin
					monitorArmed[i] <= 1'b1; // R8 R7
				end else if (grant && !extAny && intPick == 3'(i)) begin
					monitorArmed[i] <= 1'b0; // R13
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	ext_entry_a: assert property ( // R3
		grant && extAny |=> entry.load && mode == VIS_EXT
			&& entry.addr == EXT_ENTRY_BASE + ADDR_W'($past(extPick))
	) else $error("external entrance wrong");
	ext_prio_a: assert property ( // R1
		grant && extRequest[6] |=> source == 3'h6
	) else $error("channel six not first");
	int_defer_a: assert property ( // R9
		grant && extAny |=> mode != VIS_INT
	) else $error("internal beat external");
	int_entry_a: assert property ( // R10
		grant && !extAny |=> entry.load && mode == VIS_INT
			&& entry.addr == INT_ENTRY_BASE + ADDR_W'($past(intPick))
	) else $error("internal entrance wrong");
	mode_block_a: assert property ( // R4
		mode != VIS_IDLE && instr.boundary && !instr.retJump |=> !entry.load
	) else $error("entrance forced during mode");
	ext_exit_a: assert property ( // R4
		mode == VIS_EXT && !exitExt |=> mode == VIS_EXT
	) else $error("external mode left early");
	int_exit_a: assert property ( // R11
		mode == VIS_INT && exitInt |=> mode == VIS_IDLE
	) else $error("internal mode not ended");
	inhibit_a: assert property ( // R12
		inhibit && !instr.retJump |=> !entry.load
	) else $error("entrance forced while inhibited");
	boundary_a: assert property ( // R14
		!instr.boundary |=> !$rose(mode != VIS_IDLE)
	) else $error("grant off boundary");
	null_slot_a: assert property ( // R6
		instr.boundary && instr.retJump && !grant && instr.target == EXT_EXIT_ADDR
			|=> entry.load && entry.addr == EXT_NULL_ADDR && storeLower
	) else $error("no nullification");
	ret_store_a: assert property ( // R5
		instr.boundary && instr.retJump
			|=> storeLower && storeAddr == $past(instr.target)
	) else $error("return jump store missing");
	mon_hold_a: assert property ( // R13
		monitorArmed[2] && !(grant && intPick == 3'h2 && !extAny) |=> monitorArmed[2]
	) else $error("monitor lost");
	no_third_a: assert property ( // R7
		!monitorArmed[3]
	) else $error("register three armed");

	ext_cov_c: cover property (grant && extAny ##1 mode == VIS_EXT ##[1:50] mode == VIS_IDLE);
	arm_cov_c: cover property (instr.boundary && instr.func == FUNC_ARM_MON ##1 monitorArmed != 7'h00);
	int_cov_c: cover property (grant && !extAny ##1 mode == VIS_INT);
	null_cov_c: cover property (instr.boundary && instr.retJump && instr.target == INT_EXIT_ADDR);
endmodule

//--- verif/vis_periph.sv
// peripheral equipment model driving the external request lines
`timescale 1ns/100ps
module vis_periph
	import vis_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// bench asks for a request on these channels
	input  wire logic [6:1] raise,
	// sequencer status
	input  wire logic [2:0] source,
	input  wire vis_mode_t  mode,
	// request lines
	output logic      [6:1] extRequest
);
	// a line drops only once its own grant shows; a low line may wait long
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			extRequest <= 6'h00;
		end else begin
			for (int n = 1; n <= 6; n++) begin
				if (raise[n]) begin
					extRequest[n] <= 1'b1;
				end else if (mode == VIS_EXT && source == 3'(n)) begin
					extRequest[n] <= 1'b0;
				end
			end
		end
	end
endmodule

//--- verif/vis_sequencer_tb.sv
// self-checking bench for the vectored interrupt sequencer
`timescale 1ns/100ps
module vis_sequencer_tb
	import vis_pkg::*;
;
	typedef struct {logic [6:1] m; logic [2:0] s;} vis_row_t;
	logic mclk, resetn, rpt, gf;
	logic [6:1] raise, extRequest;
	logic [7:1] bufferActive, monitorArmed;
	vis_instr_t instr;
	vis_entry_t entry;
	logic [2:0] source;
	vis_mode_t mode;
	logic storeLower;
	logic [ADDR_W-1:0] storeAddr, storeData;
	int error_cnt = 0, total_checks = 0;
	// priority walk: all six raised, then drained one by one
	vis_row_t rows [7] = '{'{6'h3F, 6}, '{0, 5}, '{0, 4}, '{0, 3}, '{0, 2}, '{0, 1},
		'{6'h08, 4}};
	vis_sequencer vis_sequencer_i (.mclk(mclk), .resetn(resetn), .extRequest(extRequest),
		.bufferActive(bufferActive), .instr(instr), .entry(entry), .source(source),
		.mode(mode), .monitorArmed(monitorArmed), .storeLower(storeLower),
		.storeAddr(storeAddr), .storeData(storeData));
	vis_periph vis_periph_i (.mclk(mclk), .resetn(resetn), .raise(raise),
		.source(source), .mode(mode), .extRequest(extRequest));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one-cycle boundary report; outputs are looked at just after its edge
	task automatic bnd(input logic [5:0] f, input logic [14:0] a, input logic rj,
		input logic [14:0] t, input logic [2:0] j);
		@(posedge mclk);
		#1 instr = '{1'b1, f, a, rj, t, j, rpt, gf};
		@(posedge mclk);
		#1 instr.boundary = 1'b0;
	endtask
	task automatic rse(input logic [6:1] m);
		@(posedge mclk);
		#1 raise = m;
		@(posedge mclk);
		#1 raise = 6'h00;
	endtask
	task automatic grant(input logic [2:0] s, input logic [14:0] a, input vis_mode_t md);
		chk(entry.load, 1);
		chk(entry.addr, a);
		chk(source, s);
		chk(mode, md);
	endtask
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		{rpt, gf, raise, bufferActive} = '0;
		instr = '0;
		repeat (12) @(posedge mclk);
		#1 resetn = 1'b1;
		chk({mode, source, monitorArmed}, 0);
		foreach (rows[i]) begin
			rse(rows[i].m);
			bnd(6'h00, 15'h0100, 0, 0, 0);
			grant(rows[i].s, EXT_ENTRY_BASE + 15'(rows[i].s), VIS_EXT);
			bnd(6'h00, EXT_EXIT_ADDR, 0, 0, 0);
			chk({mode, source}, 0);
		end
		// inhibits hold off a waiting request
		rse(6'h02);
		bnd(FUNC_REPEAT, 15'h0100, 0, 0, 0);
		chk(entry.load, 0);
		rpt = 1'b1;
		bnd(6'h00, 15'h0100, 0, 0, 0);
		chk(entry.load, 0);
		{rpt, gf} = 2'b01;
		bnd(6'h00, 15'h0100, 0, 0, 0);
		chk(entry.load, 0);
		gf = 1'b0;
		bnd(6'h00, 15'h0100, 0, 0, 0);
		grant(2, 15'h000A, VIS_EXT);
		rse(6'h20);
		bnd(6'h00, 15'h0100, 0, 0, 0);
		chk(entry.load, 0);
		// entrance return jump saves the main program's next address, 0100 + 1
		bnd(6'h00, 15'h000A, 1, EXT_EXIT_ADDR, 0);
		chk({storeLower, storeAddr, storeData}, {1'b1, EXT_EXIT_ADDR, 15'h0101});
		chk(entry.addr, EXT_NULL_ADDR);
		bnd(6'h00, EXT_EXIT_ADDR, 0, 0, 0);
		bnd(6'h00, 15'h0100, 0, 0, 0);
		grant(6, 15'h000E, VIS_EXT);
		bnd(6'h00, 15'h000E, 1, 15'h0200, 0);
		chk({entry.addr, storeData}, {15'h0201, 15'h0101});
		bnd(6'h00, EXT_EXIT_ADDR, 0, 0, 0);
		// internal requests: arm 2, 7 and 3 while buffers still run
		bufferActive = 7'h42;
		bnd(FUNC_ARM_MON, 15'h0100, 0, 0, 2);
		bnd(FUNC_ARM_MON, 15'h0100, 0, 0, 7);
		bnd(FUNC_ARM_MON, 15'h0100, 0, 0, 3);
		chk({entry.load, monitorArmed}, 8'h42);
		rse(6'h01);
		bufferActive = 7'h00;
		bnd(6'h00, 15'h0100, 0, 0, 0);
		grant(1, 15'h0009, VIS_EXT);
		bnd(6'h00, EXT_EXIT_ADDR, 0, 0, 0);
		bnd(6'h00, 15'h0100, 0, 0, 0);
		grant(7, 15'h0017, VIS_INT);
		chk(monitorArmed, 7'h02);
		bnd(6'h00, EXT_EXIT_ADDR, 0, 0, 0);
		chk(mode, VIS_INT);
		bnd(6'h00, 15'h0017, 1, INT_EXIT_ADDR, 0);
		chk(entry.addr, INT_NULL_ADDR);
		bnd(6'h00, INT_EXIT_ADDR, 0, 0, 0);
		chk({mode, source}, 0);
		bnd(6'h00, 15'h0100, 0, 0, 0);
		grant(2, 15'h0012, VIS_INT);
		chk(monitorArmed, 7'h00);
		// reset dropped in the middle of an open internal mode clears everything
		resetn = 1'b0;
		#5 chk({mode, source, monitorArmed, entry.load, storeLower}, 0);
		repeat (2) @(posedge mclk);
		#1 resetn = 1'b1;
		rse(6'h10);
		bnd(6'h00, 15'h0100, 0, 0, 0);
		grant(5, 15'h000D, VIS_EXT);
		stop_test();
	end
	// hang guard: runs out only if the sequence stalls
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		stop_test();
	end
endmodule
